// ==== hdl/sdci_core.sv ====
// command decode, banks, mode register and data path of the sdram device
`timescale 1ns/10ps
`default_nettype none
module sdci_core (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        clk_en,
  input  wire logic        chip_sel_n,
  input  wire logic        row_strobe_n,
  input  wire logic        col_strobe_n,
  input  wire logic        write_en_n,
  input  wire logic        bank_sel_0,
  input  wire logic        bank_sel_1,
  input  wire logic [12:0] addr,
  input  wire logic        low_byte_mask,
  input  wire logic        high_byte_mask,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out,
  output logic      [15:0] dq_oe,
  output logic      [12:0] operating_mode_setting,
  output logic      [12:0] extended_mode_setting,
  output logic      [3:0]  bank_open,
  output logic             illegal_cmd
);
  // every pin is sampled on the rising edge
  logic [3:0]  cmd_r;
  logic [1:0]  bank_r;
  logic [12:0] addr_r;
  logic [1:0]  mask_r;
  logic [15:0] din_r;
  logic [12:0] mode_r;
  logic [12:0] ext_r;
  logic [3:0]  open_r;
  logic [12:0] row_r [0:3];
  logic [3:0]  mrd_cnt_r;
  logic        illegal_r;
  sdci_pkg::sdci_state_type state_r;
  logic [1:0]  acc_bank_r;
  logic [8:0]  acc_col_r;
  logic [8:0]  acc_step_r;
  logic [9:0]  acc_left_r;
  logic        acc_ap_r;
  logic [2:0]  acc_bl_r;
  logic        acc_bo_r;
  logic [2:0]  rd_pipe_r;
  logic [1:0]  mpipe_r [0:2];
  logic [8:0]  col_now;
  logic [15:0] rd_word;
  logic [15:0] rd_hold_r;

  always_ff @(posedge clock) begin
    if (srst) begin
      cmd_r  <= 4'hf;
      bank_r <= 2'h0;
      addr_r <= 13'h0000;
      mask_r <= 2'h3;
      din_r  <= 16'h0000;
    end else if (clk_en) begin
      cmd_r  <= {chip_sel_n, row_strobe_n, col_strobe_n, write_en_n};
      bank_r <= {bank_sel_1, bank_sel_0};
      addr_r <= addr;
      mask_r <= {high_byte_mask, low_byte_mask};
      din_r  <= dq_in;
    end
  end

  // decode; a high chip select reads as no command at all
  logic        cmd_valid;
  logic [2:0]  cmd_code;
  logic [10:0] burst_len;
  logic        full_page;
  assign cmd_valid = !cmd_r[3];
  assign cmd_code  = cmd_r[2:0];
  assign full_page = mode_r[2:0] == sdci_pkg::SDCI_BL_PAGE;

  function automatic logic [10:0] len_of(input logic [2:0] code);
    case (code)
      sdci_pkg::SDCI_BL_ONE:   len_of = 11'h001;
      sdci_pkg::SDCI_BL_TWO:   len_of = 11'h002;
      sdci_pkg::SDCI_BL_FOUR:  len_of = 11'h004;
      sdci_pkg::SDCI_BL_EIGHT: len_of = 11'h008;
      sdci_pkg::SDCI_BL_PAGE:  len_of = 11'(sdci_pkg::SDCI_PAGE_LEN);
      default:                 len_of = 11'h001;
    endcase
  endfunction
  assign burst_len = len_of(mode_r[2:0]);

  logic is_rd;
  logic is_wr;
  logic is_mode;
  assign is_rd   = cmd_valid && cmd_code == sdci_pkg::SDCI_CMD_READ[2:0];
  assign is_wr   = cmd_valid && cmd_code == sdci_pkg::SDCI_CMD_WRITE[2:0];
  assign is_mode = cmd_valid && cmd_code == sdci_pkg::SDCI_CMD_MODE_SET[2:0];

  // mode registers keep their value until the next matching mode set
  always_ff @(posedge clock) begin
    if (srst) begin
      mode_r <= sdci_pkg::SDCI_MODE_RESET;
      ext_r  <= 13'h0000;
    end else if (is_mode && bank_r == sdci_pkg::SDCI_SEL_PRIMARY) begin
      mode_r <= addr_r;
    end else if (is_mode && bank_r == sdci_pkg::SDCI_SEL_EXTENDED) begin
      ext_r  <= addr_r;
    end
  end

  // mode-set delay: accesses inside it are refused, so new settings apply after
  always_ff @(posedge clock) begin
    if (srst) begin
      mrd_cnt_r <= 4'h0;
    end else if (is_mode) begin
      mrd_cnt_r <= 4'(sdci_pkg::SDCI_MODE_SET_CYC);
    end else if (mrd_cnt_r != 4'h0) begin
      mrd_cnt_r <= mrd_cnt_r - 4'h1;
    end
  end

  // bank open state and row latch
  always_ff @(posedge clock) begin
    if (srst) begin
      open_r <= 4'h0;
      for (int i = 0; i < sdci_pkg::SDCI_BANKS; i++) begin
        row_r[i] <= 13'h0000;
      end
    end else begin
      if (cmd_valid && cmd_code == sdci_pkg::SDCI_CMD_ACTIVATE[2:0]) begin
        open_r[bank_r] <= 1'b1;
        row_r[bank_r]  <= addr_r;
      end else if (cmd_valid && cmd_code == sdci_pkg::SDCI_CMD_PRECHARGE[2:0]) begin
        if (addr_r[sdci_pkg::SDCI_AP_BIT]) begin
          open_r <= 4'h0;
        end else begin
          open_r[bank_r] <= 1'b0;
        end
      end
      // auto close once the last burst beat is done
      if (state_r != sdci_pkg::SDCI_IDLE && acc_left_r == 10'h001 && acc_ap_r) begin
        open_r[acc_bank_r] <= 1'b0;
      end
    end
  end

  logic start_ok;
  logic bad_page_ap;
  assign bad_page_ap = (is_rd || is_wr) && full_page && addr_r[sdci_pkg::SDCI_AP_BIT];
  assign start_ok    = (is_rd || is_wr) && !bad_page_ap && mrd_cnt_r == 4'h0 && open_r[bank_r];

  // illegal strobe: full page with auto close is rejected, not started
  always_ff @(posedge clock) begin
    if (srst) begin
      illegal_r <= 1'b0;
    end else begin
      illegal_r <= bad_page_ap;
    end
  end

  // burst state; new read or write interrupts the running burst
  always_ff @(posedge clock) begin
    if (srst) begin
      state_r    <= sdci_pkg::SDCI_IDLE;
      acc_bank_r <= 2'h0;
      acc_col_r  <= 9'h000;
      acc_step_r <= 9'h000;
      acc_left_r <= 10'h000;
      acc_ap_r   <= 1'b0;
      acc_bl_r   <= 3'h0;
      acc_bo_r   <= 1'b0;
    end else if (start_ok) begin
      state_r    <= is_rd ? sdci_pkg::SDCI_READ : sdci_pkg::SDCI_WRITE;
      acc_bank_r <= bank_r;
      acc_col_r  <= addr_r[8:0];
      acc_step_r <= 9'h000;
      acc_ap_r   <= addr_r[sdci_pkg::SDCI_AP_BIT];
      acc_bl_r   <= mode_r[2:0];
      acc_bo_r   <= mode_r[sdci_pkg::SDCI_BO_BIT];
      acc_left_r <= (is_wr && mode_r[sdci_pkg::SDCI_WB_BIT]) ? 10'h001 : burst_len[9:0];
    end else if (cmd_valid && cmd_code == sdci_pkg::SDCI_CMD_TERMINATE[2:0]) begin
      state_r    <= sdci_pkg::SDCI_IDLE;
      acc_left_r <= 10'h000;
    end else if (state_r != sdci_pkg::SDCI_IDLE) begin
      acc_step_r <= acc_step_r + 9'h001;
      if (acc_left_r == 10'h001 && !(acc_bl_r == sdci_pkg::SDCI_BL_PAGE && !acc_ap_r)) begin
        state_r <= sdci_pkg::SDCI_IDLE;
      end
      acc_left_r <= (acc_left_r == 10'h001) ? burst_len[9:0] : acc_left_r - 10'h001;
    end
  end

  sdci_burst_addr u_seq (
    .start_col  (acc_col_r),
    .step       (acc_step_r),
    .len_code   (acc_bl_r),
    .interleave (acc_bo_r),
    .col        (col_now)
  );

  // byte mask gates each write lane into the array
  logic        wr_go;
  assign wr_go = state_r == sdci_pkg::SDCI_WRITE;

  sdci_array u_mem (
    .clock   (clock),
    .wr_en   (wr_go),
    .wr_lane (~mask_r),
    .wr_addr ({acc_bank_r, row_r[acc_bank_r][1:0], col_now}),
    .wr_data (din_r),
    .rd_addr ({acc_bank_r, row_r[acc_bank_r][1:0], col_now}),
    .rd_data (rd_word)
  );

  // read latency pipe; latency 3 delays one more edge than latency 2
  logic lat3;
  assign lat3 = mode_r[6:4] == sdci_pkg::SDCI_RL_THREE;
  always_ff @(posedge clock) begin
    if (srst) begin
      rd_pipe_r <= 3'h0;
      mpipe_r[0] <= 2'h3;
      mpipe_r[1] <= 2'h3;
      mpipe_r[2] <= 2'h3;
    end else begin
      rd_pipe_r  <= {rd_pipe_r[1:0], state_r == sdci_pkg::SDCI_READ};
      mpipe_r[0] <= mask_r;
      mpipe_r[1] <= mpipe_r[0];
      mpipe_r[2] <= mpipe_r[1];
    end
  end

  // latency 3 enables one edge later, so its data must be one word older or bursts slip a beat
  always_ff @(posedge clock) begin
    rd_hold_r <= rd_word;
  end

  // output: data from flip-flops, lanes floated by the mask two edges on
  always_ff @(posedge clock) begin
    if (srst) begin
      dq_out <= 16'h0000;
      dq_oe  <= 16'h0000;
    end else begin
      dq_out <= lat3 ? rd_hold_r : rd_word;
      if (lat3 ? rd_pipe_r[1] : rd_pipe_r[0]) begin
        dq_oe <= {{8{~mpipe_r[0][1]}}, {8{~mpipe_r[0][0]}}};
      end else begin
        dq_oe <= 16'h0000;
      end
    end
  end

  assign operating_mode_setting = mode_r;
  assign extended_mode_setting  = ext_r;
  assign bank_open              = open_r;
  assign illegal_cmd            = illegal_r;

  // assertions
  primary_load_a: assert property (@(posedge clock) disable iff (srst)
    is_mode && bank_r == 2'h0 |=> mode_r == $past(addr_r))
    else $error("primary mode not loaded");
  ext_load_a: assert property (@(posedge clock) disable iff (srst)
    is_mode && bank_r == 2'h2 |=> $stable(mode_r) && ext_r == $past(addr_r))
    else $error("extended mode select wrong");
  deselect_ign_a: assert property (@(posedge clock) disable iff (srst)
    cmd_r[3] |=> $stable(mode_r) && ($stable(open_r) || $past(acc_ap_r)))
    else $error("deselected command acted");
  prech_all_a: assert property (@(posedge clock) disable iff (srst)
    cmd_valid && cmd_code == 3'h2 && addr_r[10] |=> open_r == 4'h0)
    else $error("precharge all left a bank open");
  sequence act_seq;
    cmd_valid && cmd_code == 3'h3;
  endsequence
  activate_open_a: assert property (@(posedge clock) disable iff (srst)
    act_seq |=> open_r[$past(bank_r)])
    else $error("activate did not open bank");
  page_ap_bad_a: assert property (@(posedge clock) disable iff (srst)
    bad_page_ap |=> illegal_r && state_r == $past(state_r))
    else $error("full page auto close not refused");
  mask_write_a: assert property (@(posedge clock) disable iff (srst)
    wr_go && mask_r == 2'h3 |-> u_mem.wr_lane == 2'h0)
    else $error("masked write stored");
  single_write_a: assert property (@(posedge clock) disable iff (srst)
    start_ok && is_wr && mode_r[9] |=> acc_left_r == 10'h001)
    else $error("single write length wrong");
  mrd_block_a: assert property (@(posedge clock) disable iff (srst)
    is_mode |=> !start_ok)
    else $error("access inside mode-set delay");
  sequence pre_one_seq;
    cmd_valid && cmd_code == 3'h2 && !addr_r[10];
  endsequence
  prech_one_a: assert property (@(posedge clock) disable iff (srst)
    pre_one_seq |=> !open_r[$past(bank_r)])
    else $error("single precharge left its bank open");
  row_latch_a: assert property (@(posedge clock) disable iff (srst)
    act_seq |=> row_r[$past(bank_r)] == $past(addr_r))
    else $error("activate row not latched");
  col_start_a: assert property (@(posedge clock) disable iff (srst)
    start_ok |=> acc_col_r == $past(addr_r[8:0]) && acc_step_r == 9'h000)
    else $error("burst start column wrong");
  auto_close_a: assert property (@(posedge clock) disable iff (srst)
    state_r != sdci_pkg::SDCI_IDLE && acc_left_r == 10'h001 && acc_ap_r |=> !open_r[$past(acc_bank_r)])
    else $error("auto close left bank open");
  burst_two_a: assert property (@(posedge clock) disable iff (srst)
    start_ok && mode_r[2:0] == 3'h1 && !(is_wr && mode_r[9]) |=> acc_left_r == 10'h002)
    else $error("burst of two has wrong length");
  mask_float_a: assert property (@(posedge clock) disable iff (srst)
    dq_oe != 16'h0000 |-> dq_oe == {{8{~$past(mask_r[1], 2)}}, {8{~$past(mask_r[0], 2)}}})
    else $error("read lanes not set by mask");
endmodule
`default_nettype wire

// ==== include/sdci_pkg.sv ====
// package of constants and types for the sdram command, init and mode block
package sdci_pkg;
  // command code {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    SDCI_CMD_MODE_SET  = 4'h0,
    SDCI_CMD_REFRESH   = 4'h1,
    SDCI_CMD_PRECHARGE = 4'h2,
    SDCI_CMD_ACTIVATE  = 4'h3,
    SDCI_CMD_WRITE     = 4'h4,
    SDCI_CMD_READ      = 4'h5,
    SDCI_CMD_TERMINATE = 4'h6,
    SDCI_CMD_NOP       = 4'h7
  } sdci_cmd_type;

  typedef enum logic [1:0] {
    SDCI_IDLE  = 2'h0,
    SDCI_READ  = 2'h1,
    SDCI_WRITE = 2'h3
  } sdci_state_type;

  localparam int           SDCI_ROW_W        = 13;
  localparam int           SDCI_COL_W        = 9;
  localparam int           SDCI_MODE_W       = 13;
  localparam int           SDCI_BANKS        = 4;
  localparam logic [12:0]  SDCI_MODE_RESET   = 13'h0020; // latency 2, burst 1
  localparam int           SDCI_WB_BIT       = 9;
  localparam int           SDCI_RL_HI        = 6;
  localparam int           SDCI_RL_LO        = 4;
  localparam int           SDCI_BO_BIT       = 3;
  localparam int           SDCI_BL_HI        = 2;
  localparam int           SDCI_AP_BIT       = 10;
  localparam logic [1:0]   SDCI_SEL_PRIMARY  = 2'h0;
  localparam logic [1:0]   SDCI_SEL_EXTENDED = 2'h2;
  localparam logic [2:0]   SDCI_RL_TWO       = 3'h2;
  localparam logic [2:0]   SDCI_RL_THREE     = 3'h3;
  localparam logic [2:0]   SDCI_BL_ONE       = 3'h0;
  localparam logic [2:0]   SDCI_BL_TWO       = 3'h1;
  localparam logic [2:0]   SDCI_BL_FOUR      = 3'h2;
  localparam logic [2:0]   SDCI_BL_EIGHT     = 3'h3;
  localparam logic [2:0]   SDCI_BL_PAGE      = 3'h7;
  localparam int           SDCI_MASK_LAT     = 2;
  localparam int           SDCI_MODE_SET_NS  = 15; // mode-set delay in ns
  localparam int           SDCI_CLK_NS       = 25;
  localparam int           SDCI_MODE_SET_CYC =
    (SDCI_MODE_SET_NS + SDCI_CLK_NS - 1) / SDCI_CLK_NS < 1 ? 1 :
    (SDCI_MODE_SET_NS + SDCI_CLK_NS - 1) / SDCI_CLK_NS;
  localparam int           SDCI_INIT_US      = 200;
  localparam int           SDCI_PAGE_LEN     = 512;
endpackage

// ==== hdl/sdci_array.sv ====
// small word memory with byte-write lanes and registered read data
`timescale 1ns/10ps
`default_nettype none
module sdci_array (
  input  wire logic        clock,
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_lane,
  input  wire logic [12:0] wr_addr,
  input  wire logic [15:0] wr_data,
  input  wire logic [12:0] rd_addr,
  output logic      [15:0] rd_data
);
  logic [15:0] mem [0:8191];

  // each lane stored only when its enable is set; masked bytes keep old data
  always_ff @(posedge clock) begin
    if (wr_en && wr_lane[0]) begin
      mem[wr_addr][7:0] <= wr_data[7:0];
    end
    if (wr_en && wr_lane[1]) begin
      mem[wr_addr][15:8] <= wr_data[15:8];
    end
  end

  // read data from a register, one cycle after the address
  always_ff @(posedge clock) begin
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ==== hdl/sdci_burst_addr.sv ====
// column sequencer for burst order and length within the burst block
`timescale 1ns/10ps
`default_nettype none
module sdci_burst_addr (
  input  wire logic [8:0] start_col,
  input  wire logic [8:0] step,
  input  wire logic [2:0] len_code,
  input  wire logic       interleave,
  output logic      [8:0] col
);
  logic [8:0] wrap_mask;
  logic [8:0] low;

  // low bits wrap inside the block; higher bits stay fixed
  always_comb begin
    case (len_code)
      sdci_pkg::SDCI_BL_TWO:   wrap_mask = 9'h001;
      sdci_pkg::SDCI_BL_FOUR:  wrap_mask = 9'h003;
      sdci_pkg::SDCI_BL_EIGHT: wrap_mask = 9'h007;
      sdci_pkg::SDCI_BL_PAGE:  wrap_mask = 9'h1ff;
      default:                 wrap_mask = 9'h000;
    endcase
    if (interleave && len_code != sdci_pkg::SDCI_BL_PAGE) begin
      low = start_col ^ step;
    end else begin
      low = 9'(start_col + step);
    end
    col = (start_col & ~wrap_mask) | (low & wrap_mask);
  end
endmodule
`default_nettype wire

// ==== bench/sdci_ctrl_model.sv ====
// memory controller model that drives the command, address, mask and data pins
`timescale 1ns/10ps
`default_nettype none
module sdci_ctrl_model #(
  parameter int INIT_CYC = sdci_pkg::SDCI_INIT_US * 1000 / sdci_pkg::SDCI_CLK_NS,
  parameter int RP_CYC   = 1,
  parameter int RFC_CYC  = 3,
  parameter int MRD_CYC  = sdci_pkg::SDCI_MODE_SET_CYC
) (
  input  wire logic        clock,
  output var  logic        clk_en,
  output var  logic        chip_sel_n,
  output var  logic        row_strobe_n,
  output var  logic        col_strobe_n,
  output var  logic        write_en_n,
  output var  logic        bank_sel_0,
  output var  logic        bank_sel_1,
  output var  logic [12:0] addr,
  output var  logic        low_byte_mask,
  output var  logic        high_byte_mask,
  output var  logic [15:0] dq_in
);
  // power-up pin state: deselected, clock enable and both masks already high
  initial begin
    clk_en = 1'b1;
    {chip_sel_n, row_strobe_n, col_strobe_n, write_en_n} = 4'hf;
    {bank_sel_1, bank_sel_0} = 2'h0;
    addr = 13'h0000;
    {high_byte_mask, low_byte_mask} = 2'h3;
    dq_in = 16'h5a5a;
  end

  // all pins but clk_en change together just after a rising edge and hold a full cycle
  task automatic drive(input logic [3:0] code, input logic [1:0] bank, input logic [12:0] a,
                       input logic [1:0] m, input logic [15:0] d);
    @(posedge clock);
    {chip_sel_n, row_strobe_n, col_strobe_n, write_en_n} <= code;
    {bank_sel_1, bank_sel_0} <= bank;
    addr <= a;
    {high_byte_mask, low_byte_mask} <= m;
    dq_in <= d;
  endtask

  // data lines without a beat keep flipping, so stale data never looks valid
  task automatic cmd(input logic [3:0] code, input logic [1:0] bank, input logic [12:0] a,
                     input logic [1:0] m);
    drive(code, bank, a, m, ~dq_in);
  endtask

  task automatic idle(input int n, input logic [1:0] m);
    repeat (n) cmd(sdci_pkg::SDCI_CMD_NOP, 2'h0, 13'h0000, m);
  endtask

  // bring-up order: long idle wait, precharge all, two refreshes, both mode sets
  task automatic power_up(input logic [12:0] mode_v, input logic [12:0] ext_v);
    idle(INIT_CYC, 2'h3);
    cmd(sdci_pkg::SDCI_CMD_PRECHARGE, 2'h0, 13'h0400, 2'h3);
    idle(RP_CYC, 2'h3);
    repeat (2) begin
      cmd(sdci_pkg::SDCI_CMD_REFRESH, 2'h0, 13'h0000, 2'h3);
      idle(RFC_CYC, 2'h3);
    end
    cmd(sdci_pkg::SDCI_CMD_MODE_SET, sdci_pkg::SDCI_SEL_EXTENDED, ext_v, 2'h3);
    idle(MRD_CYC, 2'h3);
    cmd(sdci_pkg::SDCI_CMD_MODE_SET, sdci_pkg::SDCI_SEL_PRIMARY, mode_v, 2'h3);
    idle(MRD_CYC, 2'h3);
  endtask

  // mode changes only with every bank closed, then the test row is reopened
  task automatic set_mode(input logic [12:0] v);
    cmd(sdci_pkg::SDCI_CMD_PRECHARGE, 2'h0, 13'h0400, 2'h0);
    idle(RP_CYC, 2'h0);
    cmd(sdci_pkg::SDCI_CMD_MODE_SET, sdci_pkg::SDCI_SEL_PRIMARY, v, 2'h0);
    idle(MRD_CYC, 2'h0);
    cmd(sdci_pkg::SDCI_CMD_ACTIVATE, 2'h1, 13'h0005, 2'h0);
    idle(1, 2'h0);
  endtask
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for command decode, bring-up and mode setting
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clock = 1'b0;
  logic        srst  = 1'b1;
  logic        clk_en, chip_sel_n, row_strobe_n, col_strobe_n, write_en_n;
  logic        bank_sel_0, bank_sel_1, low_byte_mask, high_byte_mask, illegal_cmd;
  logic [12:0] addr, operating_mode_setting, extended_mode_setting;
  logic [15:0] dq_in, dq_out, dq_oe, lat2, lat3, oe, d;
  logic [15:0] ill_cnt = 16'h0000;
  logic [3:0]  bank_open;
  int          num_errors = 0;
  int          checks     = 0;
  int          cyc        = 0;

  sdci_ctrl_model ctl (.clock(clock), .clk_en(clk_en), .chip_sel_n(chip_sel_n),
    .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .write_en_n(write_en_n),
    .bank_sel_0(bank_sel_0), .bank_sel_1(bank_sel_1), .addr(addr),
    .low_byte_mask(low_byte_mask), .high_byte_mask(high_byte_mask), .dq_in(dq_in));

  sdci_core i_sdci_core (.clock(clock), .srst(srst), .clk_en(clk_en), .chip_sel_n(chip_sel_n),
    .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .write_en_n(write_en_n),
    .bank_sel_0(bank_sel_0), .bank_sel_1(bank_sel_1), .addr(addr),
    .low_byte_mask(low_byte_mask), .high_byte_mask(high_byte_mask), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .operating_mode_setting(operating_mode_setting),
    .extended_mode_setting(extended_mode_setting), .bank_open(bank_open),
    .illegal_cmd(illegal_cmd));

  // 40 MHz clock
  always #12.5 clock = ~clock;

  // pulse counter; the bring-up alone takes about 8000 cycles, hence the ceiling
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (illegal_cmd === 1'b1) ill_cnt <= ill_cnt + 16'h0001;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // write burst: command, then two beats with the same lane masks
  task automatic write2(input logic [1:0] b, input logic [8:0] col, input logic ap,
                        input logic [15:0] d0, input logic [15:0] d1, input logic [1:0] m);
    ctl.cmd(sdci_pkg::SDCI_CMD_WRITE, b, {2'h0, ap, 1'b0, col}, m);
    ctl.drive(sdci_pkg::SDCI_CMD_NOP, 2'h0, 13'h0000, m, d0);
    ctl.drive(sdci_pkg::SDCI_CMD_NOP, 2'h0, 13'h0000, m, d1);
    ctl.idle(3, 2'h0);
  endtask

  // read: mask held through the read; first driven beat and its delay kept
  task automatic read1(input logic [1:0] b, input logic [8:0] col, input logic ap,
                       input logic [1:0] m, output logic [15:0] lat, output logic [15:0] oe_v,
                       output logic [15:0] dv);
    int i;
    lat = 16'h0000;
    oe_v = 16'h0000;
    dv = 16'h0000;
    ctl.cmd(sdci_pkg::SDCI_CMD_READ, b, {2'h0, ap, 1'b0, col}, m);
    for (i = 1; i <= 8; i++) begin
      ctl.idle(1, m);
      #1;
      if (lat == 16'h0000 && dq_oe !== 16'h0000) begin
        lat = 16'(i);
        oe_v = dq_oe;
        dv = dq_out;
      end
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1;
    check_val("mode after reset", 16'h0020, {3'h0, operating_mode_setting});
    check_val("extended after reset", 16'h0000, {3'h0, extended_mode_setting});
    check_val("banks after reset", 16'h0000, {12'h0, bank_open});
    check_val("enables after reset", 16'h0000, dq_oe);
    $display("test reset done");
    ctl.power_up(13'h0030, 13'h0020);
    ctl.idle(1, 2'h0);
    #1;
    check_val("primary mode", 16'h0030, {3'h0, operating_mode_setting});
    check_val("extended mode", 16'h0020, {3'h0, extended_mode_setting});
    ctl.cmd(4'h8, 2'h0, 13'h0023, 2'h0);
    ctl.idle(2, 2'h0);
    #1;
    check_val("deselected mode set", 16'h0030, {3'h0, operating_mode_setting});
    $display("test bring-up done");
    for (int b = 0; b < 4; b++) begin
      ctl.cmd(sdci_pkg::SDCI_CMD_ACTIVATE, 2'(b), 13'h1ffc + 13'(b), 2'h0);
      ctl.idle(2, 2'h0);
      #1;
      check_val("bank open", 16'((1 << (b + 1)) - 1), {12'h0, bank_open});
    end
    ctl.cmd(sdci_pkg::SDCI_CMD_PRECHARGE, 2'h2, 13'h0000, 2'h0);
    ctl.idle(2, 2'h0);
    #1;
    check_val("single precharge", 16'h000b, {12'h0, bank_open});
    ctl.cmd(sdci_pkg::SDCI_CMD_PRECHARGE, 2'h1, 13'h0400, 2'h0);
    ctl.idle(2, 2'h0);
    #1;
    check_val("precharge all", 16'h0000, {12'h0, bank_open});
    $display("test banks done");
    ctl.cmd(sdci_pkg::SDCI_CMD_ACTIVATE, 2'h1, 13'h0005, 2'h0);
    ctl.idle(1, 2'h0);
    write2(2'h1, 9'h103, 1'b0, 16'ha5c3, 16'h0f0f, 2'h0);
    write2(2'h1, 9'h103, 1'b0, 16'h1234, 16'h0f0f, 2'h1);
    read1(2'h1, 9'h103, 1'b0, 2'h0, lat3, oe, d);
    check_val("masked write data", 16'h12c3, d);
    check_val("read enables", 16'hffff, oe);
    ctl.set_mode(13'h0020);
    read1(2'h1, 9'h103, 1'b0, 2'h2, lat2, oe, d);
    check_val("masked read enables", 16'h00ff, oe);
    check_val("low byte read", 16'h00c3, d & 16'h00ff);
    check_val("latency step", 16'h0001, lat3 - lat2);
    $display("test masks and latency done");
    ctl.set_mode(13'h0021);
    write2(2'h1, 9'h0a0, 1'b0, 16'h1111, 16'h2222, 2'h0);
    ctl.set_mode(13'h0221);
    write2(2'h1, 9'h0a0, 1'b0, 16'h3333, 16'h4444, 2'h0);
    ctl.set_mode(13'h0020);
    read1(2'h1, 9'h0a0, 1'b0, 2'h0, lat2, oe, d);
    check_val("single write beat", 16'h3333, d);
    read1(2'h1, 9'h0a1, 1'b0, 2'h0, lat2, oe, d);
    check_val("burst second beat", 16'h2222, d);
    read1(2'h1, 9'h0a0, 1'b1, 2'h0, lat2, oe, d);
    check_val("auto close", 16'h0000, {12'h0, bank_open});
    ctl.set_mode(13'h002a);
    write2(2'h1, 9'h0c1, 1'b0, 16'h5555, 16'h6666, 2'h0);
    ctl.set_mode(13'h0020);
    read1(2'h1, 9'h0c0, 1'b0, 2'h0, lat2, oe, d);
    check_val("interleaved second beat", 16'h6666, d);
    $display("test write modes done");
    ctl.set_mode(13'h0027);
    write2(2'h1, 9'h000, 1'b1, 16'h7777, 16'h8888, 2'h0);
    #1;
    check_val("illegal pulses", 16'h0001, ill_cnt);
    check_val("bank kept open", 16'h0002, {12'h0, bank_open});
    $display("test full page close done");
    wrap_up();
  end
endmodule
`default_nettype wire
